/* common/fss_pkg.sv */
/*
 * Constants shared by the flash self-programming sequencer and the core-side
 * requester: register indices, field positions, reset values and op timing.
 * Assumes a single 125 MHz clock and a synchronous active-high reset.
 */
package fss_pkg;

  // Array geometry.
  localparam int FSS_ROW_WORDS = 32;
  localparam int FSS_PANEL_ROWS = 128;
  localparam int FSS_WORD_BITS = 24;
  localparam logic [23:0] FSS_ERASED_WORD = 24'hffffff;

  // Device register indices on the link.
  localparam logic [1:0] FSS_REG_CTRL = 2'h0;
  localparam logic [1:0] FSS_REG_ADDR_LOW = 2'h1;
  localparam logic [1:0] FSS_REG_ADDR_HIGH = 2'h2;
  localparam logic [1:0] FSS_REG_KEY = 2'h3;

  // Control register fields and reset value.
  localparam int FSS_CTRL_START_BIT = 15;
  localparam int FSS_CTRL_WRITE_ENABLE_BIT_BIT = 14;
  localparam int FSS_CTRL_ERR_BIT = 13;
  localparam int FSS_CTRL_OPSEL_MSB = 6;
  localparam logic [15:0] FSS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] FSS_ADDR_RESET = 16'h0000;
  localparam logic [6:0] FSS_OP_ERASE_ROW = 7'h41;
  localparam logic [6:0] FSS_OP_PROGRAM_ROW = 7'h01;

  // Unlock key values.
  localparam logic [15:0] FSS_KEY_FIRST = 16'h0055;
  localparam logic [15:0] FSS_KEY_SECOND = 16'h00aa;

  // Timing: table write two cycles, operation 2 ms at 125 MHz.
  localparam int FSS_TBL_WRITE_CYCLES = 2;
  localparam int FSS_CLK_KHZ = 125000;
  localparam int FSS_OP_TIME_MS = 2;
  localparam int FSS_OP_CYCLES = FSS_OP_TIME_MS * FSS_CLK_KHZ;

  // Request kinds on the link.
  localparam logic [1:0] FSS_KIND_TBL_READ = 2'h0;
  localparam logic [1:0] FSS_KIND_TBL_WRITE = 2'h1;
  localparam logic [1:0] FSS_KIND_REG_READ = 2'h2;
  localparam logic [1:0] FSS_KIND_REG_WRITE = 2'h3;

  // Requester software map.
  localparam logic [2:0] FSS_HOST_PAGE = 3'h0;
  localparam logic [2:0] FSS_HOST_EA = 3'h1;
  localparam logic [2:0] FSS_HOST_WDATA = 3'h2;
  localparam logic [2:0] FSS_HOST_CMD = 3'h3;
  localparam logic [2:0] FSS_HOST_RESULT = 3'h4;
  localparam logic [2:0] FSS_HOST_STATUS = 3'h5;
  localparam int FSS_CMD_HIGH_BIT = 2;
  localparam int FSS_CMD_BYTE_BIT = 3;
  localparam int FSS_CMD_INC_BIT = 4;
  localparam int FSS_CMD_SEL_LSB = 5;
  localparam logic [15:0] FSS_EA_STEP = 16'h0002;

endpackage : fss_pkg

/* common/fss_link_if.sv */
/*
 * Link between the core-side requester and the flash sequencer.
 * Assumes both ends run on the same clock; req is held until ack.
 */
interface fss_link_if;
  logic req;
  logic [1:0] kind;
  logic high;
  logic byte_mode;
  logic [7:0] page;
  logic [15:0] ea;
  logic [1:0] reg_sel;
  logic [15:0] wdata;
  logic ack;
  logic stall;
  logic [15:0] rdata;

  modport dev (input req, input kind, input high, input byte_mode, input page, input ea, input reg_sel,
               input wdata, output ack, output stall, output rdata);
  modport host (output req, output kind, output high, output byte_mode, output page, output ea,
                output reg_sel, output wdata, input ack, input stall, input rdata);
endinterface : fss_link_if

/* logic/fss_device.sv */
/*
 * Flash self-programming sequencer: table access to program flash through
 * row write latches, key-protected row erase and program, address capture.
 * Assumes the requester holds req and its fields steady until ack.
 */
// Added by the designer: the address-and-strobe port and the address map.
module fss_device
  import fss_pkg::*;
#(
  parameter int PANEL_ROWS = FSS_PANEL_ROWS,
  parameter int OP_CYCLES = FSS_OP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  fss_link_if.dev link,
  output logic op_busy,
  output logic write_error
);

  localparam int MEM_WORDS = PANEL_ROWS * FSS_ROW_WORDS;
  localparam int AW = $clog2(MEM_WORDS);
  localparam int CW = $clog2(OP_CYCLES + 1);
  localparam logic [CW-1:0] OP_LAST = CW'(OP_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_TWR = 4'b0010,
    S_OP = 4'b0100,
    S_ACK = 4'b1000
  } fss_dev_state_type;

  fss_dev_state_type state_r;
  logic [CW-1:0] cnt_r;
  logic start_r;
  logic write_enable_bit_r;
  logic err_r;
  logic [6:0] opsel_r;
  logic [15:0] addr_low_r;
  logic [7:0] addr_high_r;
  logic key_first_r;
  logic key_armed_r;
  logic [15:0] rdata_r;
  logic [23:0] latch_r [FSS_ROW_WORDS];
  logic [23:0] mem_r [MEM_WORDS];

  logic take;
  logic is_reg_write;
  logic start_req;
  logic start_ok;
  logic op_fire;
  logic [23:0] tbl_addr;
  logic [23:0] cap_addr;
  logic [AW-1:0] tbl_index;
  logic [4:0] latch_index;
  logic [AW-1:0] row_base;
  logic [23:0] tbl_word;
  logic [15:0] tbl_read_val;
  logic [15:0] reg_read_val;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode.

  // A request is taken only in idle, so the core waits out every busy period.
  assign take = (state_r == S_IDLE) && link.req;
  assign is_reg_write = link.kind == FSS_KIND_REG_WRITE;
  assign start_req = take && is_reg_write && (link.reg_sel == FSS_REG_CTRL) && link.wdata[FSS_CTRL_START_BIT];
  // Start needs enable, a known operation and the key pair as the previous two requests.
  assign start_ok = start_req && link.wdata[FSS_CTRL_WRITE_ENABLE_BIT_BIT] && key_armed_r &&
                    (link.wdata[6:0] == FSS_OP_ERASE_ROW || link.wdata[6:0] == FSS_OP_PROGRAM_ROW);
  assign op_fire = (state_r == S_OP) && (cnt_r == OP_LAST);

  // Program address is the page byte joined to the effective address.
  assign tbl_addr = {link.page, link.ea};
  assign tbl_index = tbl_addr[AW:1];
  assign latch_index = link.ea[5:1];
  // The row is chosen by the capture registers, low word bits dropped.
  assign cap_addr = {addr_high_r, addr_low_r};
  assign row_base = cap_addr[AW:1] & ~AW'(FSS_ROW_WORDS - 1);

  assign link.ack = state_r == S_ACK;
  assign link.stall = state_r == S_OP;
  assign link.rdata = rdata_r;
  assign op_busy = start_r;
  assign write_error = err_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: table writes take two cycles, accepted start writes hold for the op.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          cnt_r <= '0;
          if (take && link.kind == FSS_KIND_TBL_WRITE) begin
            state_r <= S_TWR;
          end else if (start_ok) begin
            state_r <= S_OP;
          end else if (take) begin
            state_r <= S_ACK;
          end
        end
        S_TWR: begin
          state_r <= S_ACK;
        end
        S_OP: begin
          cnt_r <= cnt_r + CW'(1);
          if (op_fire) begin
            state_r <= S_ACK;
          end
        end
        S_ACK: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key tracking; any request other than the next key step disarms.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      key_first_r <= 1'b0;
      key_armed_r <= 1'b0;
    end else if (take) begin
      key_first_r <= is_reg_write && link.reg_sel == FSS_REG_KEY && link.wdata == FSS_KEY_FIRST;
      key_armed_r <= is_reg_write && link.reg_sel == FSS_REG_KEY && link.wdata == FSS_KEY_SECOND &&
                     key_first_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; a refused start leaves start low and raises the error.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      start_r <= FSS_CTRL_RESET[FSS_CTRL_START_BIT];
      write_enable_bit_r <= FSS_CTRL_RESET[FSS_CTRL_WRITE_ENABLE_BIT_BIT];
      err_r <= FSS_CTRL_RESET[FSS_CTRL_ERR_BIT];
      opsel_r <= FSS_CTRL_RESET[FSS_CTRL_OPSEL_MSB:0];
    end else if (op_fire) begin
      start_r <= 1'b0;
    end else if (take && is_reg_write && link.reg_sel == FSS_REG_CTRL) begin
      start_r <= start_ok;
      write_enable_bit_r <= link.wdata[FSS_CTRL_WRITE_ENABLE_BIT_BIT];
      opsel_r <= link.wdata[FSS_CTRL_OPSEL_MSB:0];
      // Software may clear the error, but a refused start in the same write wins.
      err_r <= link.wdata[FSS_CTRL_ERR_BIT] || (start_req && !start_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address capture from table ops or direct writes.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_low_r <= FSS_ADDR_RESET;
      addr_high_r <= FSS_ADDR_RESET[7:0];
    end else if (take && (link.kind == FSS_KIND_TBL_READ || link.kind == FSS_KIND_TBL_WRITE)) begin
      addr_low_r <= link.ea;
      addr_high_r <= link.page;
    end else if (take && is_reg_write && link.reg_sel == FSS_REG_ADDR_LOW) begin
      addr_low_r <= link.wdata;
    end else if (take && is_reg_write && link.reg_sel == FSS_REG_ADDR_HIGH) begin
      addr_high_r <= link.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write latches: filled on the second cycle of a table write.

  // The latch slot follows the address, so an ascending fill from a row
  // boundary lands instruction n in slot n.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < FSS_ROW_WORDS; i++) begin
        latch_r[i] <= FSS_ERASED_WORD;
      end
    end else if (state_r == S_TWR) begin
      if (!link.high && !link.byte_mode) begin
        latch_r[latch_index][15:0] <= link.wdata;
      end else if (!link.high && !link.ea[0]) begin
        latch_r[latch_index][7:0] <= link.wdata[7:0];
      end else if (!link.high) begin
        latch_r[latch_index][15:8] <= link.wdata[7:0];
      end else if (!link.byte_mode || !link.ea[0]) begin
        latch_r[latch_index][23:16] <= link.wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash array: changes only when a started operation ends.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_r[i] <= FSS_ERASED_WORD;
      end
    end else if (op_fire) begin
      for (int i = 0; i < FSS_ROW_WORDS; i++) begin
        if (opsel_r == FSS_OP_ERASE_ROW) begin
          mem_r[row_base + AW'(i)] <= FSS_ERASED_WORD;
        end else begin
          mem_r[row_base + AW'(i)] <= latch_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection.

  // Byte reads put the chosen byte low; the phantom top byte reads zero.
  always_comb begin
    tbl_word = mem_r[tbl_index];
    if (!link.high && !link.byte_mode) begin
      tbl_read_val = tbl_word[15:0];
    end else if (!link.high) begin
      tbl_read_val = {8'h00, link.ea[0] ? tbl_word[15:8] : tbl_word[7:0]};
    end else if (!link.byte_mode || !link.ea[0]) begin
      tbl_read_val = {8'h00, tbl_word[23:16]};
    end else begin
      tbl_read_val = 16'h0000;
    end
  end

  // The key register is write-only and reads as zero.
  always_comb begin
    case (link.reg_sel)
      FSS_REG_CTRL: reg_read_val = {start_r, write_enable_bit_r, err_r, 6'h00, opsel_r};
      FSS_REG_ADDR_LOW: reg_read_val = addr_low_r;
      FSS_REG_ADDR_HIGH: reg_read_val = {8'h00, addr_high_r};
      default: reg_read_val = 16'h0000;
    endcase
  end

  // Read data stand from the taking edge until the next taken read request.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else if (take && link.kind == FSS_KIND_TBL_READ) begin
      rdata_r <= tbl_read_val;
    end else if (take && link.kind == FSS_KIND_REG_READ) begin
      rdata_r <= reg_read_val;
    end
  end

endmodule : fss_device

/* logic/fss_host.sv */
/*
 * Core-side requester: turns software register writes into single table or
 * register requests on the link and collects their answers.
 * Assumes a software port with read data one cycle after the read strobe.
 */
module fss_host
  import fss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  fss_link_if.host link
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } fss_host_state_type;

  fss_host_state_type state_r;
  logic [7:0] page_r;
  logic [15:0] ea_r;
  logic [15:0] wdata_r;
  logic [15:0] cmd_r;
  logic [15:0] result_r;
  logic [15:0] sw_rdata_r;
  logic cmd_go;

  // Only one request is outstanding, so nothing can slip between the two
  // key writes or the start write and its completion.
  assign cmd_go = sw_wr && sw_addr == FSS_HOST_CMD && state_r == H_IDLE;

  assign link.req = state_r == H_WAIT;
  assign link.kind = cmd_r[1:0];
  assign link.high = cmd_r[FSS_CMD_HIGH_BIT];
  assign link.byte_mode = cmd_r[FSS_CMD_BYTE_BIT];
  assign link.reg_sel = cmd_r[FSS_CMD_SEL_LSB+1:FSS_CMD_SEL_LSB];
  assign link.page = page_r;
  assign link.ea = ea_r;
  assign link.wdata = wdata_r;
  assign sw_rdata = sw_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Request state; the link fields are held until ack.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= H_IDLE;
      cmd_r <= 16'h0000;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (cmd_go) begin
            cmd_r <= sw_wdata;
            state_r <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.ack) begin
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and data registers; writes while a request is open are ignored.

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      page_r <= 8'h00;
      ea_r <= 16'h0000;
      wdata_r <= 16'h0000;
    end else if (state_r == H_WAIT) begin
      // Post-increment steps one instruction for an ascending latch fill.
      if (link.ack && cmd_r[FSS_CMD_INC_BIT]) begin
        ea_r <= ea_r + FSS_EA_STEP;
      end
    end else if (sw_wr && sw_addr == FSS_HOST_PAGE) begin
      page_r <= sw_wdata[7:0];
    end else if (sw_wr && sw_addr == FSS_HOST_EA) begin
      ea_r <= sw_wdata;
    end else if (sw_wr && sw_addr == FSS_HOST_WDATA) begin
      wdata_r <= sw_wdata;
    end
  end

  // Result captured on every ack.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_r <= 16'h0000;
    end else if (state_r == H_WAIT && link.ack) begin
      result_r <= link.rdata;
    end
  end

  // Software read port; unmapped addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sw_rdata_r <= 16'h0000;
    end else if (sw_rd) begin
      case (sw_addr)
        FSS_HOST_PAGE: sw_rdata_r <= {8'h00, page_r};
        FSS_HOST_EA: sw_rdata_r <= ea_r;
        FSS_HOST_WDATA: sw_rdata_r <= wdata_r;
        FSS_HOST_CMD: sw_rdata_r <= cmd_r;
        FSS_HOST_RESULT: sw_rdata_r <= result_r;
        FSS_HOST_STATUS: sw_rdata_r <= {14'h0000, link.stall, state_r == H_WAIT};
        default: sw_rdata_r <= 16'h0000;
      endcase
    end else begin
      sw_rdata_r <= 16'h0000;
    end
  end

endmodule : fss_host

/* verif/fss_link_asserts.sv */
/*
 * Checker for the link between the requester and the sequencer.
 * Assumes one clock, a synchronous active-high reset and instantiation beside the link.
 */
module fss_link_asserts
  import fss_pkg::*;
#(
  parameter int OP_CYCLES = FSS_OP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic [1:0] kind,
  input wire logic high,
  input wire logic byte_mode,
  input wire logic [7:0] page,
  input wire logic [15:0] ea,
  input wire logic [1:0] reg_sel,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic stall,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] stall_len_r;
  logic key_step_r;
  logic armed_r;
  logic start_w;
  logic key_w;
  logic start_ok_w;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Request decode; a start with a bad op select must never stall.
  assign start_w = kind == FSS_KIND_REG_WRITE && reg_sel == FSS_REG_CTRL && wdata[FSS_CTRL_START_BIT];
  assign key_w = kind == FSS_KIND_REG_WRITE && reg_sel == FSS_REG_KEY;
  assign start_ok_w = req && start_w && wdata[FSS_CTRL_WRITE_ENABLE_BIT_BIT] &&
                      (wdata[6:0] == FSS_OP_ERASE_ROW || wdata[6:0] == FSS_OP_PROGRAM_ROW);

  // Stall length counter, so long operations need no long repetition.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !stall) begin
      stall_len_r <= 32'h0;
    end else begin
      stall_len_r <= stall_len_r + 32'h1;
    end
  end

  // Key arming as answered on the link; any other answered request disarms.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      key_step_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (ack) begin
      key_step_r <= key_w && wdata == FSS_KEY_FIRST;
      armed_r <= key_step_r && key_w && wdata == FSS_KEY_SECOND;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_hold;
    req && !ack |=> req && $stable({kind, high, byte_mode, page, ea, reg_sel, wdata});
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after ack");
  property p_tbl_write_two;
    $rose(req) && kind == FSS_KIND_TBL_WRITE |-> !ack && !stall ##1 !ack && !stall ##1 ack;
  endproperty
  a_tbl_write_two: assert property (p_tbl_write_two) else $error("table write timing wrong");
  property p_short_answer; $rose(req) && kind != FSS_KIND_TBL_WRITE && !start_w |-> ##1 ack; endproperty
  a_short_answer: assert property (p_short_answer) else $error("register or read answer late");
  property p_stall_cause; $rose(stall) |-> armed_r && $past(start_ok_w); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("operation started without unlock");
  property p_stall_len; $fell(stall) |-> stall_len_r == OP_CYCLES && ack; endproperty
  a_stall_len: assert property (p_stall_len) else $error("operation length or end wrong");
  property p_stall_max; stall |-> stall_len_r < OP_CYCLES && req && !ack; endproperty
  a_stall_max: assert property (p_stall_max) else $error("stall overran or request lost");
  property p_key_hidden; ack && kind == FSS_KIND_REG_READ && reg_sel == FSS_REG_KEY |-> rdata == 16'h0000; endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("key register readable");

  // Main scenarios reached.
  c_op_done: cover property ($fell(stall));
  c_tbl_write: cover property ($rose(req) && kind == FSS_KIND_TBL_WRITE);
  c_refused: cover property ($rose(req) && start_w ##1 ack && !stall);
endmodule : fss_link_asserts

/* verif/flash_self_programming_sequencer_tb.sv */
/*
 * Self-checking bench: requester and sequencer joined by the link, driven over
 * the software port. Assumes the shared package; operations shortened to 20 cycles.
 */
module flash_self_programming_sequencer_tb
  import fss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OP_CYC = 20;
  typedef struct packed {logic [1:0] sel; logic [15:0] wr; logic [15:0] exp;} fss_case_type;
  localparam fss_case_type ROWS [5] = '{'{FSS_REG_ADDR_LOW, 16'h1234, 16'h1234},
    '{FSS_REG_ADDR_HIGH, 16'h12ab, 16'h00ab}, '{FSS_REG_KEY, 16'h0055, 16'h0000},
    '{FSS_REG_CTRL, 16'h4041, 16'h4041}, '{FSS_REG_CTRL, 16'h0001, 16'h0001}};
  logic ref_clk;
  logic sys_rst;
  logic [2:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [15:0] sw_rdata;
  logic op_busy;
  logic write_error;
  logic [15:0] v;
  int error_cnt;
  int checks_done;
  int stall_cnt;
  int n0;
  int busy_cnt;
  int b0;

  ////////////////////////////////////////////////////////////////////////////
  // Both ends face each other; the checker watches the link between them.
  fss_link_if u_fss_link_if();
  fss_host u_fss_host(.ref_clk(ref_clk), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(u_fss_link_if.host));
  fss_device #(.PANEL_ROWS(4), .OP_CYCLES(OP_CYC)) u_fss_device(.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(u_fss_link_if.dev), .op_busy(op_busy), .write_error(write_error));
  fss_link_asserts #(.OP_CYCLES(OP_CYC)) u_fss_link_asserts(.ref_clk(ref_clk), .sys_rst(sys_rst),
    .req(u_fss_link_if.req), .kind(u_fss_link_if.kind), .high(u_fss_link_if.high),
    .byte_mode(u_fss_link_if.byte_mode), .page(u_fss_link_if.page), .ea(u_fss_link_if.ea),
    .reg_sel(u_fss_link_if.reg_sel), .wdata(u_fss_link_if.wdata), .ack(u_fss_link_if.ack),
    .stall(u_fss_link_if.stall), .rdata(u_fss_link_if.rdata));

  // Clock, and counts of stalled and busy cycles for measuring operation length.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (u_fss_link_if.stall === 1'b1) stall_cnt++;
    if (op_busy === 1'b1) busy_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Software port cycles; read data is taken just after the edge that returns it.
  task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : sw_read
  // Issue a command, then poll until the request closes, so none overlap.
  task automatic run_cmd(input logic [1:0] k, input logic hi, input logic byt, input logic inc, input logic [1:0] sel);
    logic [15:0] s;
    int n;
    sw_write(FSS_HOST_CMD, {9'h000, sel, inc, byt, hi, k});
    s = 16'h0001;
    n = 0;
    while (s[0] !== 1'b0 && n < 100) begin
      sw_read(FSS_HOST_STATUS, s);
      n++;
    end
    check("request closed", {15'h0000, s[0]}, 16'h0000);
  endtask : run_cmd
  task automatic reg_wr(input logic [1:0] sel, input logic [15:0] d);
    sw_write(FSS_HOST_WDATA, d);
    run_cmd(FSS_KIND_REG_WRITE, 1'b0, 1'b0, 1'b0, sel);
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] sel, output logic [15:0] d);
    run_cmd(FSS_KIND_REG_READ, 1'b0, 1'b0, 1'b0, sel);
    sw_read(FSS_HOST_RESULT, d);
  endtask : reg_rd
  task automatic tbl_rd(input logic [15:0] a, input logic hi, input logic byt, output logic [15:0] d);
    sw_write(FSS_HOST_EA, a);
    run_cmd(FSS_KIND_TBL_READ, hi, byt, 1'b0, 2'h0);
    sw_read(FSS_HOST_RESULT, d);
  endtask : tbl_rd
  task automatic op_seq(input logic [6:0] op, input logic [15:0] k1, input logic [15:0] k2, input logic en);
    reg_wr(FSS_REG_CTRL, {1'b0, en, 7'h00, op});
    reg_wr(FSS_REG_KEY, k1);
    reg_wr(FSS_REG_KEY, k2);
    reg_wr(FSS_REG_CTRL, {1'b1, en, 7'h00, op});
  endtask : op_seq

  ////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well beyond the thousand or so cycles the tests need.
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end

  // Main sequence: reset, register rows, then capture, program, erase, refusals.
  initial begin
    sys_rst = 1'b1;
    sw_addr = 3'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    stall_cnt = 0;
    busy_cnt = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reg_rd(FSS_REG_CTRL, v);
    check("ctrl reset", v, FSS_CTRL_RESET);
    tbl_rd(16'h0040, 1'b0, 1'b0, v);
    check("erased word", v, 16'hffff);
    foreach (ROWS[i]) begin
      reg_wr(ROWS[i].sel, ROWS[i].wr);
      reg_rd(ROWS[i].sel, v);
      check("register row", v, ROWS[i].exp);
    end
    sw_write(FSS_HOST_PAGE, 16'h0005);
    tbl_rd(16'h1236, 1'b1, 1'b0, v);
    reg_rd(FSS_REG_ADDR_LOW, v);
    check("capture low", v, 16'h1236);
    reg_rd(FSS_REG_ADDR_HIGH, v);
    check("capture high", v, 16'h0005);
    sw_write(FSS_HOST_PAGE, 16'h0000);
    sw_write(FSS_HOST_EA, 16'h0040);
    for (int i = 0; i < FSS_ROW_WORDS; i++) begin
      sw_write(FSS_HOST_WDATA, {8'ha5, 8'(i)});
      run_cmd(FSS_KIND_TBL_WRITE, 1'b0, 1'b0, 1'b0, 2'h0);
      sw_write(FSS_HOST_WDATA, {8'h00, 8'h5a ^ 8'(i)});
      run_cmd(FSS_KIND_TBL_WRITE, 1'b1, 1'b0, 1'b1, 2'h0);
    end
    tbl_rd(16'h0040, 1'b0, 1'b0, v);
    check("latch only", v, 16'hffff);
    n0 = stall_cnt;
    b0 = busy_cnt;
    op_seq(FSS_OP_PROGRAM_ROW, FSS_KEY_FIRST, FSS_KEY_SECOND, 1'b1);
    check("program stall", 16'(stall_cnt - n0), 16'(OP_CYC));
    check("program busy", 16'(busy_cnt - b0), 16'(OP_CYC));
    reg_rd(FSS_REG_CTRL, v);
    check("start cleared", v, 16'h4001);
    for (int i = 0; i < 32; i += 31) begin
      tbl_rd(16'h0040 + 16'(2 * i), 1'b0, 1'b0, v);
      check("program low", v, {8'ha5, 8'(i)});
      tbl_rd(16'h0040 + 16'(2 * i), 1'b1, 1'b0, v);
      check("program high", v, {8'h00, 8'h5a ^ 8'(i)});
    end
    tbl_rd(16'h0080, 1'b0, 1'b0, v);
    check("next row kept", v, 16'hffff);
    tbl_rd(16'h0043, 1'b0, 1'b1, v);
    check("low byte read", v, 16'h00a5);
    tbl_rd(16'h0042, 1'b1, 1'b1, v);
    check("high byte read", v, 16'h005b);
    reg_wr(FSS_REG_ADDR_HIGH, 16'h0000);
    reg_wr(FSS_REG_ADDR_LOW, 16'h0044);
    n0 = stall_cnt;
    b0 = busy_cnt;
    op_seq(FSS_OP_ERASE_ROW, FSS_KEY_FIRST, FSS_KEY_SECOND, 1'b1);
    check("erase stall", 16'(stall_cnt - n0), 16'(OP_CYC));
    check("erase busy", 16'(busy_cnt - b0), 16'(OP_CYC));
    tbl_rd(16'h007e, 1'b0, 1'b0, v);
    check("row erased", v, 16'hffff);
    // Reversed keys, no write enable, and a repeated first key must all be refused.
    for (int c = 0; c < 3; c++) begin
      n0 = stall_cnt;
      b0 = busy_cnt;
      op_seq(c == 2 ? FSS_OP_ERASE_ROW : FSS_OP_PROGRAM_ROW, c == 0 ? FSS_KEY_SECOND : FSS_KEY_FIRST,
        c == 1 ? FSS_KEY_SECOND : (c == 0 ? FSS_KEY_FIRST : FSS_KEY_FIRST), c != 1);
      check("refused stall", 16'(stall_cnt - n0), 16'h0000);
      check("refused busy", 16'(busy_cnt - b0), 16'h0000);
      check("error output", {15'h0000, write_error}, 16'h0001);
      reg_wr(FSS_REG_CTRL, 16'h0000);
      reg_rd(FSS_REG_CTRL, v);
      check("error cleared", v, 16'h0000);
    end
    tbl_rd(16'h0040, 1'b0, 1'b0, v);
    check("array untouched", v, 16'hffff);
    reg_wr(FSS_REG_CTRL, 16'h6041);
    check("error set by write", {15'h0000, write_error}, 16'h0001);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reg_rd(FSS_REG_CTRL, v);
    check("ctrl after reset", v, FSS_CTRL_RESET);
    check("error after reset", {15'h0000, write_error}, 16'h0000);
    check("busy after reset", {15'h0000, op_busy}, 16'h0000);
    wrap_up();
  end
endmodule : flash_self_programming_sequencer_tb
